/* logic/tmr_pkg.sv */
// package for the auto-reload / capture timer
// assumes a 32-bit apb slave with word-aligned registers
package tmr_pkg;

    // register byte offsets
    localparam logic [7:0] ctrl_off   = 8'h00;
    localparam logic [7:0] reload_off = 8'h04;
    localparam logic [7:0] count_off  = 8'h08;
    localparam logic [7:0] status_off = 8'h0c;
    localparam logic [7:0] mask_off   = 8'h10;

    // ctrl field positions
    localparam int ctrl_run_bit    = 0;
    localparam int ctrl_cnt_bit    = 1;
    localparam int ctrl_cap_bit    = 2;
    localparam int ctrl_ud_bit     = 3;
    localparam int ctrl_exen_bit   = 4;
    localparam int ctrl_rise_bit   = 5;
    localparam int ctrl_width      = 6;

    // status field positions
    localparam int st_reload_bit   = 0;
    localparam int st_capture_bit  = 1;
    localparam int st_width        = 2;

    // reset and wrap values
    localparam logic [5:0]  ctrl_reset  = 6'h00;
    localparam logic [15:0] count_reset = 16'h0000;
    localparam logic [15:0] max_count   = 16'hffff;
    localparam logic [15:0] cap_reload  = 16'h0000;

    // timing: timer tick divisor in pclk periods
    localparam int timer_div = 12;

    typedef struct packed {
        logic rise_edge;
        logic ext_en;
        logic up_down;
        logic capture;
        logic counter;
        logic run;
    } ctrl_t;

    typedef struct packed {
        logic rise;
        logic fall;
        logic level;
    } pin_evt_t;

endpackage

/* logic/pin_sync.sv */
// two-stage synchroniser with edge detector on the second stage
// assumes pin is asynchronous to pclk
module pin_sync
(
    // clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // pin
    input  wire logic               pin,
    // events
    output tmr_pkg::pin_evt_t       evt
);
    logic meta;
    logic sync;
    logic prev;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta <= 1'b0;
            sync <= 1'b0;
            prev <= 1'b0;
        end
        else
        begin
            meta <= pin;
            sync <= meta;
            prev <= sync;
        end
    end

    // edges seen only when two successive samples differ
    assign evt.fall  = prev & ~sync;
    assign evt.rise  = ~prev & sync;
    assign evt.level = sync;
endmodule // pin_sync

/* logic/auto_reload_capture_timer.sv */
// 16-bit auto-reload / capture timer with apb register access
// assumes synchronous apb master; count and control pins may be asynchronous
//
// The implementer's own choices: the APB slave port and the register addresses.
module auto_reload_capture_timer
#(
    parameter int tick_div = tmr_pkg::timer_div
)
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // pins
    input  wire logic        count_input_pin,
    input  wire logic        external_control_pin,
    // interrupt
    output logic             irq
);
    ////////////////////////////////////////////////////////////////////////
    // elaboration check: prescaler is eight bits wide
    if (tick_div < 2 || tick_div > 255)
    begin : g_bad_div
        $error("tick_div out of range");
    end

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    tmr_pkg::pin_evt_t cnt_evt;
    tmr_pkg::pin_evt_t ext_evt;

    pin_sync u_cnt_sync
    (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     (count_input_pin),
        .evt     (cnt_evt)
    );

    pin_sync u_ext_sync
    (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     (external_control_pin),
        .evt     (ext_evt)
    );

    ////////////////////////////////////////////////////////////////////////
    // registers
    tmr_pkg::ctrl_t                  ctrl;
    logic [15:0]                     count_register;
    logic [15:0]                     reload_capture_register;
    logic [tmr_pkg::st_width-1:0]    status;
    logic [tmr_pkg::st_width-1:0]    mask;
    logic [7:0]                      prescale;

    ////////////////////////////////////////////////////////////////////////
    // apb decode
    wire access    = psel & penable;
    wire wr        = access & pwrite;
    wire sel_ctrl  = (paddr == tmr_pkg::ctrl_off);
    wire sel_rel   = (paddr == tmr_pkg::reload_off);
    wire sel_cnt   = (paddr == tmr_pkg::count_off);
    wire sel_stat  = (paddr == tmr_pkg::status_off);
    wire sel_mask  = (paddr == tmr_pkg::mask_off);
    wire mapped    = sel_ctrl | sel_rel | sel_cnt | sel_stat | sel_mask;

    assign pready  = 1'b1;
    assign pslverr = access & ~mapped;

    logic [31:0] rd_mux;
    always_comb
    begin
        if (sel_ctrl)
            rd_mux = {26'h0000000, ctrl};
        else if (sel_rel)
            rd_mux = {16'h0000, reload_capture_register};
        else if (sel_cnt)
            rd_mux = {16'h0000, count_register};
        else if (sel_stat)
            rd_mux = {30'h00000000, status};
        else if (sel_mask)
            rd_mux = {30'h00000000, mask};
        else
            rd_mux = 32'h00000000;
    end
    assign prdata = rd_mux;

    ////////////////////////////////////////////////////////////////////////
    // count enable
    wire last_tick  = (prescale == 8'(tick_div - 1));
    wire tick       = ctrl.counter ? cnt_evt.fall : last_tick;
    wire step       = ctrl.run & tick;

    // control pin edge per selected polarity
    wire ext_edge   = ctrl.ext_en & (ctrl.rise_edge ? ext_evt.rise : ext_evt.fall);

    // mode decode
    wire mode_cap   = ctrl.capture;
    wire mode_ud    = ~mode_cap & ctrl.up_down;
    wire dir_up     = ~mode_ud | ext_evt.level;
    wire at_top     = (count_register == tmr_pkg::max_count);
    wire at_bottom  = (count_register == reload_capture_register);

    wire ovf        = step & dir_up & at_top;
    wire unf        = step & ~dir_up & at_bottom;
    wire ext_reload = ~mode_cap & ~mode_ud & ext_edge;
    wire capture_ev = mode_cap & ext_edge;
    wire reload_ev  = ovf | unf | ext_reload;

    // interrupt sources: none in up/down mode
    wire set_reload  = (ovf | ext_reload) & ~mode_ud;
    wire set_capture = capture_ev;

    logic [15:0] next_count;
    always_comb
    begin
        if (mode_cap && ovf)
            next_count = tmr_pkg::cap_reload;
        else if (unf)
            next_count = tmr_pkg::max_count;
        else if (reload_ev)
            next_count = reload_capture_register;
        else if (step && dir_up)
            next_count = count_register + 16'h0001;
        else if (step)
            next_count = count_register - 16'h0001;
        else
            next_count = count_register;
    end

    wire [tmr_pkg::st_width-1:0] set_bits = {set_capture, set_reload};
    wire [tmr_pkg::st_width-1:0] clr_bits =
        (wr && sel_stat) ? pwdata[tmr_pkg::st_width-1:0] : '0;

    ////////////////////////////////////////////////////////////////////////
    // state
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl     <= tmr_pkg::ctrl_reset;
            prescale <= 8'h00;
            mask     <= '0;
            status   <= '0;
        end
        else
        begin
            prescale <= (last_tick || !ctrl.run) ? 8'h00 : prescale + 8'h01;
            status   <= (status & ~clr_bits) | set_bits;
            if (wr && sel_ctrl)
                ctrl <= pwdata[tmr_pkg::ctrl_width-1:0];
            if (wr && sel_mask)
                mask <= pwdata[tmr_pkg::st_width-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count_register          <= tmr_pkg::count_reset;
            reload_capture_register <= tmr_pkg::count_reset;
        end
        else
        begin
            if (wr && sel_cnt)
                count_register <= pwdata[15:0];
            else
                count_register <= next_count;
            if (capture_ev)
                reload_capture_register <= count_register;
            else if (wr && sel_rel)
                reload_capture_register <= pwdata[15:0];
        end
    end

    assign irq = |(status & mask);

    ////////////////////////////////////////////////////////////////////////
    // assertions
    a_timer_rate: assert property (@(posedge pclk) disable iff (!presetn)
        (tick_div >= 9 && ctrl.run && !ctrl.counter && step)
        |=> (!step || ctrl.counter) [*8])
        else $error("timer stepped faster than divider");

    a_counter_fall: assert property (@(posedge pclk) disable iff (!presetn)
        (ctrl.counter && step) |-> $past(cnt_evt.level) && !cnt_evt.level)
        else $error("counter stepped without falling edge");

    a_up_wrap: assert property (@(posedge pclk) disable iff (!presetn)
        (ovf && !mode_cap && !(wr && (sel_cnt || sel_rel)))
        |=> count_register == $past(reload_capture_register))
        else $error("overflow did not reload");

    a_ext_reload: assert property (@(posedge pclk) disable iff (!presetn)
        (ext_reload && !(wr && sel_cnt)) |=> count_register == $past(reload_capture_register))
        else $error("edge reload missing");

    a_reload_irq: assert property (@(posedge pclk) disable iff (!presetn)
        (reload_ev && !mode_ud) |=> status[tmr_pkg::st_reload_bit])
        else $error("reload flag not set");

    a_ud_no_irq: assert property (@(posedge pclk) disable iff (!presetn)
        mode_ud |=> (status & ~$past(status)) == '0)
        else $error("interrupt event in up/down mode");

    a_down_wrap: assert property (@(posedge pclk) disable iff (!presetn)
        (unf && !(wr && sel_cnt)) |=> count_register == 16'hffff)
        else $error("underflow did not load ffff");

    a_cap_wrap: assert property (@(posedge pclk) disable iff (!presetn)
        (mode_cap && ovf && !(wr && sel_cnt)) |=> count_register == 16'h0000)
        else $error("capture overflow did not clear");

    a_capture_copy: assert property (@(posedge pclk) disable iff (!presetn)
        capture_ev |=> reload_capture_register == $past(count_register)
                       && status[tmr_pkg::st_capture_bit])
        else $error("capture value wrong");
endmodule // auto_reload_capture_timer

/* verification/pin_model.sv */
// model of the external count and control pins
// assumes the bench calls its tasks; pins move just after pclk edges
module pin_model
(
    // clock
    input  wire logic pclk,
    // pins
    output logic      count_pin,
    output logic      ctrl_pin
);
    timeunit 1ns;
    timeprecision 100ps;

    initial
    begin
        count_pin = 1'b1;
        ctrl_pin  = 1'b0;
    end

    // falling edges, low gap cycles and high gap+1 cycles, gap at least 12
    task automatic count_edges(input int n, input int gap);
        repeat (n)
        begin
            @(posedge pclk) count_pin <= 1'b0;
            repeat (gap) @(posedge pclk);
            count_pin <= 1'b1;
            repeat (gap) @(posedge pclk);
        end
    endtask

    // control pin level, held long enough for the synchroniser
    task automatic set_ctrl(input logic v);
        @(posedge pclk) ctrl_pin <= v;
        repeat (8) @(posedge pclk);
    endtask
endmodule // pin_model

/* verification/auto_reload_capture_timer_tb.sv */
// self-checking bench for the auto-reload / capture timer
// assumes pin_model drives the pins and apb answers without wait states
module auto_reload_capture_timer_tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        cnt_pin;
    logic        ctl_pin;
    logic        irq;
    logic [32:0] expq[$];
    logic [15:0] rnd;
    logic [15:0] base;
    int          failures = 0;
    int          checked = 0;
    int          cyc = 0;
    int          t0;
    int          n;

    auto_reload_capture_timer i_auto_reload_capture_timer
    (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .count_input_pin(cnt_pin),
        .external_control_pin(ctl_pin), .irq(irq)
    );
    pin_model i_pin_model (.pclk(pclk), .count_pin(cnt_pin), .ctrl_pin(ctl_pin));

    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic wrap_up;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic done(input string s);
        $display("end of test %s", s);
    endtask

    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        input logic [32:0] e);
        if (!w)
            expq.push_back(e);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 33'h0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0, {1'b0, e});
    endtask

    task automatic wait_irq(input logic v);
        int k;
        k = 0;
        while (irq !== v && k < 200)
        begin
            @(negedge pclk);
            k++;
        end
        chk({32'h0, irq}, {32'h0, v});
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // read results compared against the oldest note
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            failures++;
            wrap_up;
        end
        if (psel && penable && pready && !pwrite)
            chk({pslverr, prdata}, expq.pop_front());
    end

    initial
    begin
        presetn = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0;
        rnd     = 16'd6766;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rd(tmr_pkg::ctrl_off, 32'h0);
        rd(tmr_pkg::count_off, 32'h0);
        xfer(1'b0, 8'h14, 32'h0, {1'b1, 32'h0});
        done("reset");
        wr(tmr_pkg::reload_off, 32'hffff);
        wr(tmr_pkg::count_off, 32'hffff);
        wr(tmr_pkg::mask_off, 32'h1);
        wr(tmr_pkg::ctrl_off, 32'h1);
        wait_irq(1'b1);
        t0 = cyc;
        wr(tmr_pkg::status_off, 32'h1);
        wait_irq(1'b0);
        wait_irq(1'b1);
        chk(33'(cyc - t0), 33'd12);
        wr(tmr_pkg::ctrl_off, 32'h0);
        rd(tmr_pkg::status_off, 32'h1);
        wr(tmr_pkg::status_off, 32'h1);
        wr(tmr_pkg::mask_off, 32'h0);
        done("timer");
        rnd = lfsr(rnd);
        base = {4'h0, rnd[11:0]};
        n = int'(rnd[14:12]) + 1;
        wr(tmr_pkg::count_off, {16'h0, base});
        wr(tmr_pkg::ctrl_off, 32'h3);
        i_pin_model.count_edges(n, 12 + 20 * int'(rnd[15]));
        rd(tmr_pkg::count_off, {16'h0, base + 16'(n)});
        done("counter");
        i_pin_model.set_ctrl(1'b1);
        wr(tmr_pkg::reload_off, 32'habcd);
        wr(tmr_pkg::ctrl_off, 32'h13);
        i_pin_model.set_ctrl(1'b0);
        rd(tmr_pkg::count_off, 32'habcd);
        rd(tmr_pkg::status_off, 32'h1);
        wait_irq(1'b0);
        wr(tmr_pkg::mask_off, 32'h1);
        wait_irq(1'b1);
        wr(tmr_pkg::status_off, 32'h1);
        wait_irq(1'b0);
        done("edge reload");
        wr(tmr_pkg::reload_off, 32'h10);
        wr(tmr_pkg::count_off, 32'h11);
        wr(tmr_pkg::ctrl_off, 32'hb);
        i_pin_model.count_edges(2, 12);
        rd(tmr_pkg::count_off, 32'hffff);
        i_pin_model.set_ctrl(1'b1);
        i_pin_model.count_edges(1, 12);
        rd(tmr_pkg::count_off, 32'h10);
        rd(tmr_pkg::status_off, 32'h0);
        done("up down");
        i_pin_model.set_ctrl(1'b0);
        wr(tmr_pkg::count_off, 32'h321);
        wr(tmr_pkg::ctrl_off, 32'h37);
        i_pin_model.set_ctrl(1'b1);
        rd(tmr_pkg::reload_off, 32'h321);
        wr(tmr_pkg::count_off, 32'hffff);
        i_pin_model.count_edges(1, 12);
        rd(tmr_pkg::count_off, 32'h0);
        rd(tmr_pkg::status_off, 32'h3);
        done("capture");
        wrap_up;
    end
endmodule // auto_reload_capture_timer_tb
